// ### hw/drv_ctl_pkg.sv
// constants, register map and frame layout for the output driver control block
// assumes a 100 MHz system clock and a serial link sampled by that clock
package drv_ctl_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int LINK_MAX_HZ = 50_000_000;
    localparam int POR_SETTLE_CYCLES = 4;

    localparam int WORD_BITS = 16;
    localparam logic [4:0] WORD_BITS_5 = 5'h10;

    // frame field positions, msb first on the wire
    localparam int F_ADDR_HI = 15;
    localparam int F_ADDR_LO = 13;
    localparam int F_RW = 12;
    localparam int F_ZERO_HI = 11;
    localparam int F_RANGE_HI = 10;
    localparam int F_RANGE_LO = 7;
    localparam int F_CLEAR_LEVEL_CHOICE = 6;
    localparam int F_OUTPUT_DRIVE_ON = 5;
    localparam int F_CLEAR = 4;
    localparam int F_RSET = 3;
    localparam int F_RESET = 2;

    // range codes that select the current channel
    localparam logic [3:0] RANGE_I_4_20 = 4'h0;
    localparam logic [3:0] RANGE_I_0_20 = 4'h1;
    localparam logic [3:0] RANGE_I_0_24 = 4'h2;

    // avalon register byte offsets
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h04;
    localparam logic [4:0] ADDR_LAST_WORD = 5'h08;
    localparam logic [4:0] ADDR_CFG = 5'h0c;
    localparam logic [4:0] ADDR_ERRCNT = 5'h10;

    localparam logic [1:0] CFG_RESET = 2'h1;
    localparam int CFG_LISTEN = 0;
    localparam int CFG_STRICT = 1;

    typedef struct packed {
        logic [3:0] range_code;
        logic clear_level_choice;
        logic output_drive_on;
        logic clear_cmd;
        logic rset_internal;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{default: 1'b0};

    typedef struct packed {
        logic [2:0] slot;
        logic read_not_write;
        logic zero_hi;
        logic [3:0] range_code;
        logic clear_level_choice;
        logic output_drive_on;
        logic clear_cmd;
        logic rset_internal;
        logic soft_reset;
        logic [1:0] zero_lo;
    } frame_t;

    typedef struct packed {
        logic iout_en;
        logic vout_en;
        logic vout_zero;
        logic clear_active;
    } drive_t;

    typedef enum logic [1:0] {
        ST_POR,
        ST_SW,
        ST_HW
    } mode_t;

endpackage

// ### hw/output_driver_control_logic.sv
// control logic of a single channel voltage/current output driver
// serial link, strap and control pins arrive asynchronously and are synchronised here;
// i_sys_rst stands in for the power-on reset of the part
`timescale 1ns/1ps

// How it works
// - sense strap mode at power up
// - software mode, clear high: drive zero volts
// - software mode, clear low: voltage tristate
// - current channel starts tristate in software mode
// - clear still high at enable: clear level
// - hardware mode follows range, enable, clear pins
// - power-on reset zeroes the control and output registers; cfg resets to listen
// - software mode powers up with outputs off
// - software reset by pin or bit
// - reset returns outputs to power-on state
// - reset pin acts on level
// - reset bit returns to zero itself
// - no reset in hardware mode
// - disabled output tristates both channels outside the zero-volt hold
// - never drive both channels together
// - grounded strap selects software mode
// - sixteen bits msb first, falling edge
// - top three bits carry device address
// - only the slot-matching device acts
module output_driver_control_logic
    import drv_ctl_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_sclk,
    input wire logic i_sdin,
    input wire logic i_sync_n,
    input wire logic i_clear,
    input wire logic i_reset_n,
    input wire logic i_config_source_strap,
    input wire logic [2:0] i_board_slot_strap,
    input wire logic [3:0] i_range_code,
    input wire logic i_output_drive_on,
    input wire logic i_clear_level_choice,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_iout_drive_en,
    output logic o_vout_drive_en,
    output logic o_vout_force_zero,
    output logic o_clear_active,
    output logic [3:0] o_range_code,
    output logic o_clear_level_choice
);

    function automatic logic is_current_range(input logic [3:0] code);
        return code == RANGE_I_4_20 || code == RANGE_I_0_20 || code == RANGE_I_0_24;
    endfunction

    // two-flop synchronisers; only the second stage is read
    logic [10:0] sync_a;
    logic [10:0] sync_b;
    logic sclk_prev;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            // pins start at their idle levels so no false serial clock edge follows reset
            sync_a <= 11'h700;
            sync_b <= 11'h700;
            sclk_prev <= 1'b1;
        end else begin
            sync_a <= {i_reset_n, i_sync_n, i_sclk, i_sdin, i_clear, i_config_source_strap,
                       i_output_drive_on, i_clear_level_choice, i_board_slot_strap};
            sync_b <= sync_a;
            sclk_prev <= sync_b[8];
        end
    end

    logic reset_n_s;
    logic sync_n_s;
    logic sclk_s;
    logic sdin_s;
    logic clear_s;
    logic strap_s;
    logic hw_output_drive_on_s;
    logic hw_clear_level_choice_s;
    logic [2:0] slot_s;
    logic [3:0] range_a;
    logic [3:0] range_s;

    assign {reset_n_s, sync_n_s, sclk_s, sdin_s, clear_s, strap_s, hw_output_drive_on_s, hw_clear_level_choice_s, slot_s} = sync_b;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            range_a <= 4'h0;
            range_s <= 4'h0;
        end else begin
            range_a <= i_range_code;
            range_s <= range_a;
        end
    end

    // serial shift register; the link is sampled, so the ref clock must run
    // well over twice the serial clock and the full link rate is not reachable
    logic sclk_fall;
    logic [15:0] shift;
    logic [4:0] bit_cnt;
    logic word_done;

    assign sclk_fall = sclk_prev && !sclk_s;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            shift <= 16'h0000;
            bit_cnt <= 5'h00;
            word_done <= 1'b0;
        end else begin
            word_done <= 1'b0;
            if (sync_n_s) begin
                bit_cnt <= 5'h00;
            end else if (sclk_fall && bit_cnt != WORD_BITS_5) begin
                shift <= {shift[14:0], sdin_s};
                bit_cnt <= bit_cnt + 5'h01;
                word_done <= bit_cnt == WORD_BITS_5 - 5'h01;
            end
        end
    end

    frame_t frame;
    logic [1:0] cfg;
    logic slot_hit;
    logic bad_bits;
    logic accept;

    assign frame = frame_t'(shift);
    assign slot_hit = frame.slot == slot_s;
    assign bad_bits = frame.zero_hi || frame.zero_lo != 2'h0;
    assign accept = word_done && slot_hit && !frame.read_not_write && cfg[CFG_LISTEN] &&
                    !(cfg[CFG_STRICT] && bad_bits);

    // power-up mode sensing
    mode_t mode;
    logic [2:0] por_cnt;
    logic pwrup_zero;
    ctrl_t ctrl;
    logic sw_reset;

    assign sw_reset = mode == ST_SW && (!reset_n_s || (accept && frame.soft_reset));

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            mode <= ST_POR;
            por_cnt <= 3'h0;
        end else begin
            unique case (mode)
                ST_POR: begin
                    por_cnt <= por_cnt + 3'h1;
                    if (por_cnt == 3'(POR_SETTLE_CYCLES - 1)) begin
                        mode <= strap_s ? ST_HW : ST_SW;
                    end
                end
                ST_SW: mode <= ST_SW;
                ST_HW: mode <= ST_HW;
            endcase
        end
    end

    // zero-volt hold taken at power up and after every software reset
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            pwrup_zero <= 1'b0;
        end else if (mode == ST_POR) begin
            pwrup_zero <= clear_s;
        end else if (sw_reset) begin
            pwrup_zero <= clear_s;
        end else if (mode == ST_SW && ctrl.output_drive_on) begin
            pwrup_zero <= 1'b0;
        end
    end

    // control register; a reset command zeroes it, so the reset bit never stays set
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ctrl <= CTRL_RESET;
        end else if (mode != ST_SW || sw_reset) begin
            ctrl <= CTRL_RESET;
        end else if (accept) begin
            ctrl.range_code <= frame.range_code;
            ctrl.clear_level_choice <= frame.clear_level_choice;
            ctrl.output_drive_on <= frame.output_drive_on;
            ctrl.clear_cmd <= frame.clear_cmd;
            ctrl.rset_internal <= frame.rset_internal;
        end
    end

    // output drive decision
    logic [3:0] eff_range;
    logic eff_output_drive_on;
    logic eff_clear;
    logic eff_clear_level_choice;
    drive_t next_drive;

    always_comb begin
        eff_range = mode == ST_HW ? range_s : ctrl.range_code;
        eff_output_drive_on = mode == ST_HW ? hw_output_drive_on_s : (mode == ST_SW && ctrl.output_drive_on);
        eff_clear = clear_s || (mode == ST_SW && ctrl.clear_cmd);
        eff_clear_level_choice = mode == ST_HW ? hw_clear_level_choice_s : (ctrl.clear_level_choice || hw_clear_level_choice_s);
        next_drive = '{default: 1'b0};
        if (eff_output_drive_on) begin
            // exactly one channel per range code
            next_drive.iout_en = is_current_range(eff_range);
            next_drive.vout_en = !is_current_range(eff_range);
            next_drive.clear_active = eff_clear;
        end else if (mode == ST_SW && pwrup_zero) begin
            next_drive.vout_en = 1'b1;
            next_drive.vout_zero = 1'b1;
        end
        // anything else leaves both channels tristate
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_iout_drive_en <= 1'b0;
            o_vout_drive_en <= 1'b0;
            o_vout_force_zero <= 1'b0;
            o_clear_active <= 1'b0;
            o_range_code <= 4'h0;
            o_clear_level_choice <= 1'b0;
        end else begin
            o_iout_drive_en <= next_drive.iout_en;
            o_vout_drive_en <= next_drive.vout_en;
            o_vout_force_zero <= next_drive.vout_zero;
            o_clear_active <= next_drive.clear_active;
            o_range_code <= eff_range;
            o_clear_level_choice <= eff_clear_level_choice;
        end
    end

    // diagnostics kept for software
    logic [15:0] last_word;
    logic [7:0] err_cnt;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            last_word <= 16'h0000;
            err_cnt <= 8'h00;
        end else if (word_done && slot_hit) begin
            last_word <= shift;
            if (bad_bits && err_cnt != 8'hff) begin
                err_cnt <= err_cnt + 8'h01;
            end
        end
    end

    // avalon slave: one wait cycle, answer on the second edge of a request
    logic req;
    logic [31:0] next_rdata;

    assign req = i_avs_read || i_avs_write;

    always_comb begin
        unique case (i_avs_address)
            ADDR_CTRL: next_rdata = {24'h0, ctrl.range_code, ctrl.clear_level_choice, ctrl.output_drive_on,
                                      ctrl.clear_cmd, ctrl.rset_internal};
            ADDR_STATUS: next_rdata = {24'h0, slot_s, clear_s, !reset_n_s, pwrup_zero,
                                        mode == ST_HW, mode == ST_SW};
            ADDR_LAST_WORD: next_rdata = {16'h0, last_word};
            ADDR_CFG: next_rdata = {30'h0, cfg};
            ADDR_ERRCNT: next_rdata = {24'h0, err_cnt};
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0;
        end else begin
            o_avs_waitrequest <= !(req && o_avs_waitrequest);
            if (i_avs_read && o_avs_waitrequest) begin
                o_avs_readdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            cfg <= CFG_RESET;
        end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == ADDR_CFG && i_avs_byteenable[0]) begin
            cfg <= i_avs_writedata[1:0];
        end
    end

    // checks
    sequence s_enable_word;
        accept && frame.output_drive_on && !frame.soft_reset && !(!reset_n_s);
    endsequence

    sequence s_foreign_word;
        word_done && !slot_hit;
    endsequence

    a_channels_exclusive: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        !(o_iout_drive_en && o_vout_drive_en)) else $error("both output channels driven");

    a_por_regs_zero: assert property (@(posedge i_ref_clk)
        i_sys_rst |=> ctrl == CTRL_RESET && !o_iout_drive_en && !o_vout_drive_en)
        else $error("registers not zero after power-on reset");

    a_reset_pin_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        mode == ST_SW && !reset_n_s [*3] |-> !ctrl.output_drive_on && !o_iout_drive_en)
        else $error("output enabled while reset pin low");

    a_reset_bit_clears: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        mode == ST_SW && accept && frame.soft_reset |=> ctrl == CTRL_RESET ##1 !o_iout_drive_en)
        else $error("reset command left control state set");

    a_enable_takes_range: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (mode == ST_SW and s_enable_word) |=> ctrl.output_drive_on && ctrl.range_code == $past(frame.range_code)
        ##1 o_range_code == ctrl.range_code)
        else $error("enable write did not take range");

    a_foreign_ignored: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (mode == ST_SW && reset_n_s and s_foreign_word) |=> $stable(ctrl))
        else $error("word for another slot changed control state");

    a_disabled_tristate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        mode == ST_SW && !ctrl.output_drive_on && !pwrup_zero |=> !o_iout_drive_en && !o_vout_drive_en)
        else $error("disabled output still driven");

    a_powerup_iout_off: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        mode == ST_SW && pwrup_zero && !ctrl.output_drive_on |=> o_vout_force_zero && !o_iout_drive_en)
        else $error("power-up zero state wrong");

    a_hw_no_reset: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        mode == ST_HW |-> ctrl == CTRL_RESET && !sw_reset)
        else $error("reset acted in hardware mode");

    a_bus_one_wait: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        req && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer timing wrong");

endmodule // output_driver_control_logic

// ### hw/drv_ctl_notes_unused.sv
// spare file: every piece of logic sits in output_driver_control_logic.sv

// ### test/serial_host_model.sv
// controller model: drives the frame, serial clock and data pins of the block
// assumes the caller waits for one send to finish before starting the next
`timescale 1ns/1ps
module serial_host_model (
    output logic o_sclk,
    output logic o_sdin,
    output logic o_sync_n
);
    // serial clock stands high between frames
    initial begin
        o_sclk = 1'b1;
        o_sdin = 1'b0;
        o_sync_n = 1'b1;
    end

    // n_bits below 16 raises the frame pin early to abort the word
    task automatic send_word(input logic [15:0] w, input int n_bits);
        #3;
        o_sync_n = 1'b0;
        for (int i = 0; i < n_bits; i++) begin
            o_sdin = w[15-i];
            #40 o_sclk = 1'b0;
            #40 o_sclk = 1'b1;
        end
        #40 o_sync_n = 1'b1;
        // released data line must not keep the last bit
        o_sdin = ~o_sdin;
        #40;
    endtask
endmodule // serial_host_model

// ### test/testbench.sv
// self-checking bench for the output driver control block
// assumes serial_host_model on the link pins; the Avalon master tasks live here
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module testbench
    import drv_ctl_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clear = 1'b0;
    logic reset_n = 1'b1;
    logic strap = 1'b0;
    logic [2:0] slot = 3'h0;
    logic [3:0] rng_pin = 4'h0;
    logic en_pin = 1'b0;
    logic cs_pin = 1'b0;
    logic [4:0] av_addr = 5'h00;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wdata = 32'h0;
    logic [3:0] av_be = 4'hf;
    logic [31:0] rdata, rd;
    logic waitreq, iout, vout, vzero, clr_act, cs_out;
    logic [3:0] rng_out;
    logic sclk, sdin, sync_n;
    int n_fail = 0;
    int n_checks = 0;
    logic [3:0] r = 4'h0, rtab [6] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9};
    logic en, cs;
    logic [15:0] w;

    always #5 clk = ~clk;

    serial_host_model host (.o_sclk(sclk), .o_sdin(sdin), .o_sync_n(sync_n));

    output_driver_control_logic uut (
        .i_ref_clk(clk), .i_sys_rst(sys_rst), .i_sclk(sclk), .i_sdin(sdin), .i_sync_n(sync_n),
        .i_clear(clear), .i_reset_n(reset_n), .i_config_source_strap(strap), .i_board_slot_strap(slot),
        .i_range_code(rng_pin), .i_output_drive_on(en_pin), .i_clear_level_choice(cs_pin),
        .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
        .i_avs_byteenable(av_be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .o_iout_drive_en(iout), .o_vout_drive_en(vout), .o_vout_force_zero(vzero),
        .o_clear_active(clr_act), .o_range_code(rng_out), .o_clear_level_choice(cs_out));

    task automatic wrap_up();
        if (n_fail == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // request held until waitrequest is sampled low; data taken at that edge
    task automatic av_xfer(input logic [4:0] a, input logic wr, input logic [31:0] wd);
        @(posedge clk);
        av_addr <= a;
        av_wdata <= wd;
        av_rd <= !wr;
        av_wr <= wr;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        rd = rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask

    task automatic por(input logic hw, input logic clr);
        @(posedge clk);
        sys_rst <= 1'b1;
        strap <= hw;
        clear <= clr;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        `CHK({iout, vout, vzero, clr_act, rng_out, waitreq}, 9'h001)
        repeat (10) @(posedge clk);
    endtask

    // zero kept in bits 11, 1 and 0 unless a fault is meant
    function automatic logic [15:0] fr(logic [2:0] s, logic [3:0] rg, logic c, logic e, logic rst);
        return {s, 1'b0, 1'b0, rg, c, e, 1'b0, 1'b0, rst, 2'b00};
    endfunction

    function automatic logic [3:0] exp_drv(logic [3:0] rg, logic e, logic c);
        return {e & (rg <= 4'h2), e & (rg > 4'h2), 1'b0, e & c};
    endfunction

    task automatic send(input logic [15:0] word, input int n);
        host.send_word(word, n);
        repeat (8) @(posedge clk);
    endtask

    initial begin
        #300_000;
        n_fail++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h88d9));
        slot <= 3'($urandom);
        por(1'b0, 1'b0);
        `CHK({iout, vout, vzero}, 3'h0)
        av_xfer(ADDR_STATUS, 1'b0, 32'h0);
        `CHK(rd, {24'h0, slot, 5'h01})
        av_xfer(ADDR_CFG, 1'b0, 32'h0);
        `CHK(rd, 32'h1)
        av_xfer(5'h14, 1'b0, 32'h0);
        `CHK(rd, 32'h0)
        por(1'b0, 1'b1);
        `CHK({iout, vzero}, 2'b01)
        av_xfer(ADDR_STATUS, 1'b0, 32'h0);
        `CHK(rd, {24'h0, slot, 5'h15})
        send(fr(slot, 4'h0, 1'b0, 1'b1, 1'b0), 16);
        `CHK({iout, vout, vzero, clr_act}, 4'h9)
        clear <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK({iout, vout, vzero, clr_act}, 4'h8)
        for (int i = 0; i < 14; i++) begin
            send(fr(slot, r, 1'b0, 1'b0, 1'b0), 16);
            `CHK({iout, vout}, 2'b00)
            r = rtab[$urandom_range(5, 0)];
            en = 1'($urandom);
            cs = 1'($urandom);
            cs_pin <= 1'($urandom);
            w = fr(slot, r, cs, en, 1'b0);
            send(w, 16);
            `CHK({iout, vout, vzero, clr_act}, exp_drv(r, en, 1'b0))
            `CHK({rng_out, cs_out}, {r, cs | cs_pin})
            av_xfer(ADDR_CTRL, 1'b0, 32'h0);
            `CHK(rd, {24'h0, r, cs, en, 2'b00})
            av_xfer(ADDR_LAST_WORD, 1'b0, 32'h0);
            `CHK(rd, {16'h0, w})
        end
        send(fr(slot, 4'h6, 1'b0, 1'b1, 1'b0), 16);
        send(fr(slot ^ 3'h1, 4'h0, 1'b0, 1'b1, 1'b0), 16);
        send(fr(slot, 4'h1, 1'b0, 1'b1, 1'b0), 12);
        `CHK({iout, vout, rng_out}, 6'h16)
        av_xfer(ADDR_CTRL, 1'b1, 32'hff);
        av_xfer(ADDR_CTRL, 1'b0, 32'h0);
        `CHK(rd, 32'h64)
        send(fr(slot, 4'h0, 1'b0, 1'b1, 1'b1), 16);
        `CHK({iout, vout, vzero, clr_act}, 4'h0)
        av_xfer(ADDR_CTRL, 1'b0, 32'h0);
        `CHK(rd, 32'h0)
        send(fr(slot, 4'h0, 1'b0, 1'b1, 1'b0), 16);
        `CHK({iout, vout}, 2'b10)
        reset_n <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK({iout, vout}, 2'b00)
        send(fr(slot, 4'h5, 1'b0, 1'b1, 1'b0), 16);
        `CHK({iout, vout}, 2'b00)
        reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK({iout, vout}, 2'b00)
        send(fr(slot, 4'h5, 1'b0, 1'b1, 1'b0) | 16'h0001, 16);
        av_xfer(ADDR_ERRCNT, 1'b0, 32'h0);
        `CHK({rd, vout}, 33'h3)
        av_xfer(ADDR_CFG, 1'b1, 32'h3);
        send(fr(slot, 4'h0, 1'b0, 1'b1, 1'b0) | 16'h0800, 16);
        av_xfer(ADDR_ERRCNT, 1'b0, 32'h0);
        `CHK({rd, vout}, 33'h5)
        rng_pin <= 4'h6;
        en_pin <= 1'b1;
        por(1'b1, 1'b0);
        `CHK({iout, vout, rng_out}, 6'h16)
        av_xfer(ADDR_STATUS, 1'b0, 32'h0);
        `CHK(rd, {24'h0, slot, 5'h02})
        send(fr(slot, 4'h0, 1'b0, 1'b0, 1'b1), 16);
        `CHK({iout, vout}, 2'b01)
        en_pin <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK({iout, vout}, 2'b00)
        rng_pin <= 4'h1;
        en_pin <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK({iout, vout}, 2'b10)
        wrap_up();
    end
endmodule // testbench
